// File: hdl/pimb_mask_bank.sv
`timescale 1ns/1ps
`include "pimb_map.svh"
// How it works
// - Mask bit 5 passes comparator rise or fall flag requests when set.
// - Mask bit 4 passes the ADC conversion-complete request when set.
// - Mask bit 3 passes counter array requests when set.
// - Mask bit 2 passes the ADC window-compare request when set.
// - Mask bit 1 passes the port-match request when set.
// - Mask bit 0 passes the two-wire controller request when set.
module pimb_mask_bank (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire pimb_pkg::pimb_sfr_t  sfr,
  input  wire pimb_pkg::pimb_flags_t flags,
  output logic [7:0]                sfr_rdata,
  output pimb_pkg::pimb_req_t       irq_req,
  output logic [5:0]                irq_mask
);

  ////////////////////////////////////////////////////////////
  // Sizes

  // One mask bit per gated source; the top two register bits are reserved
  localparam int unsigned NUM_SRC  = 6;
  localparam int unsigned REG_BITS = 8;

  ////////////////////////////////////////////////////////////
  // Decoding helpers

  // Write and read paths share one address decode
  function automatic logic addr_hit(
    input logic [7:0] addr
  );
    return addr == `PIMB_MASK1_ADDR;
  endfunction

  // Comparator keeps two edge flags behind a single mask bit
  function automatic logic [5:0] src_vec(
    input pimb_pkg::pimb_flags_t f
  );
    logic [5:0] v;
    v                       = 6'h00;
    v[`PIMB_BIT_COMPARATOR] = f.comparator_rise_flag | f.comparator_fall_flag;
    v[`PIMB_BIT_ADC_DONE]   = f.adc_done_flag;
    v[`PIMB_BIT_COUNTER]    = f.counter_array_flag;
    v[`PIMB_BIT_ADC_WINDOW] = f.adc_window_flag;
    v[`PIMB_BIT_PORT_MATCH] = f.port_match_flag;
    v[`PIMB_BIT_TWOWIRE]    = f.twowire_flag;
    return v;
  endfunction

  // Bit positions back to the named request fields
  function automatic pimb_pkg::pimb_req_t req_pack(
    input logic [5:0] v
  );
    pimb_pkg::pimb_req_t r;
    r               = '0;
    r.comparator    = v[`PIMB_BIT_COMPARATOR];
    r.adc_done      = v[`PIMB_BIT_ADC_DONE];
    r.counter_array = v[`PIMB_BIT_COUNTER];
    r.adc_window    = v[`PIMB_BIT_ADC_WINDOW];
    r.port_match    = v[`PIMB_BIT_PORT_MATCH];
    r.twowire       = v[`PIMB_BIT_TWOWIRE];
    return r;
  endfunction

  // Reserved bits never reach storage or the read port
  function automatic logic [7:0] keep_rw(
    input logic [7:0] v
  );
    return v & `PIMB_RW_BITS;
  endfunction

  ////////////////////////////////////////////////////////////
  // Bus decode

  logic wr_hit;
  logic rd_hit;

  assign wr_hit = sfr.wr & addr_hit(sfr.addr);
  assign rd_hit = sfr.rd & addr_hit(sfr.addr);

  ////////////////////////////////////////////////////////////
  // Mask register

  logic [REG_BITS-1:0] mask_ff;
  logic [REG_BITS-1:0] nxt_mask;

  always_comb begin
    nxt_mask = mask_ff;
    if (wr_hit) begin
      nxt_mask = keep_rw(sfr.wdata);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_ff <= `PIMB_MASK1_RESET;
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  ////////////////////////////////////////////////////////////
  // Mask copy on its own port

  // Fed from the next value so it never lags the register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_mask <= 6'h00;
    end else begin
      irq_mask <= nxt_mask[NUM_SRC-1:0];
    end
  end

  ////////////////////////////////////////////////////////////
  // Read port; unmapped addresses read zero

  logic [REG_BITS-1:0] nxt_rdata;

  always_comb begin
    nxt_rdata = 8'h00;
    if (rd_hit) begin
      nxt_rdata = keep_rw(mask_ff);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////
  // Gating

  logic [NUM_SRC-1:0] src;
  logic [NUM_SRC-1:0] nxt_req;

  assign src = src_vec(flags);

  // Flags are only read here, so masking leaves them pending
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_gate
    assign nxt_req[i] = src[i] & mask_ff[i];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_req <= '0;
    end else begin
      irq_req <= req_pack(nxt_req);
    end
  end

endmodule

// File: hdl/pimb_map.svh
`ifndef PIMB_MAP_SVH
`define PIMB_MAP_SVH

// Register location on the special-function register bus
`define PIMB_MASK1_ADDR     8'he6
`define PIMB_MASK1_RESET    8'h00

// Mask bit positions
`define PIMB_BIT_TWOWIRE    0
`define PIMB_BIT_PORT_MATCH 1
`define PIMB_BIT_ADC_WINDOW 2
`define PIMB_BIT_COUNTER    3
`define PIMB_BIT_ADC_DONE   4
`define PIMB_BIT_COMPARATOR 5

// Writable bits; bits 7:6 are reserved, drop writes and read back zero
`define PIMB_RW_BITS        8'h3f

`endif

// File: hdl/pimb_pkg.sv
package pimb_pkg;

  // Pending flags from the six peripheral sources
  typedef struct packed {
    logic comparator_rise_flag;
    logic comparator_fall_flag;
    logic adc_done_flag;
    logic counter_array_flag;
    logic adc_window_flag;
    logic port_match_flag;
    logic twowire_flag;
  } pimb_flags_t;

  // Masked requests toward the processor interrupt logic
  typedef struct packed {
    logic comparator;
    logic adc_done;
    logic counter_array;
    logic adc_window;
    logic port_match;
    logic twowire;
  } pimb_req_t;

  // Special-function register bus access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pimb_sfr_t;

endpackage

// File: tb/pimb_flag_src.sv
`timescale 1ns/1ps
module pimb_flag_src (
  input  wire logic            clk,
  input  wire logic [6:0]      val,
  output pimb_pkg::pimb_flags_t flags
);
  // Flags are levels that only their source clears
  always_ff @(posedge clk) flags <= val;
endmodule

// File: tb/pimb_mask_bank_chk.sv
`timescale 1ns/1ps
`include "pimb_map.svh"
module pimb_mask_bank_chk (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire pimb_pkg::pimb_sfr_t   sfr,
  input wire logic [7:0]            sfr_rdata,
  input wire pimb_pkg::pimb_flags_t flags,
  input wire pimb_pkg::pimb_req_t   irq_req,
  input wire logic [5:0]            irq_mask
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_b5; irq_req[5] == $past((flags[6] | flags[5]) & irq_mask[5]); endproperty
  a_b5: assert property (p_b5) else $error("b5");
  property p_b4; irq_req[4] == $past(flags[4] & irq_mask[4]); endproperty
  a_b4: assert property (p_b4) else $error("b4");
  property p_b3; irq_req[3] == $past(flags[3] & irq_mask[3]); endproperty
  a_b3: assert property (p_b3) else $error("b3");
  property p_b2; irq_req[2] == $past(flags[2] & irq_mask[2]); endproperty
  a_b2: assert property (p_b2) else $error("b2");
  property p_b1; irq_req[1] == $past(flags[1] & irq_mask[1]); endproperty
  a_b1: assert property (p_b1) else $error("b1");
  property p_b0; irq_req[0] == $past(flags[0] & irq_mask[0]); endproperty
  a_b0: assert property (p_b0) else $error("b0");
  property p_all; $stable(flags) && $stable(irq_mask) |=> $stable(irq_req); endproperty
  a_all: assert property (p_all) else $error("req");
  property p_rd; sfr.rd && sfr.addr == `PIMB_MASK1_ADDR |=> sfr_rdata == {2'b00, $past(irq_mask)}; endproperty
  a_rd: assert property (p_rd) else $error("read data");
  property p_rd0; !(sfr.rd && sfr.addr == `PIMB_MASK1_ADDR) |=> sfr_rdata == 8'h00; endproperty
  a_rd0: assert property (p_rd0) else $error("idle read data");
  property p_wr; sfr.wr && sfr.addr == `PIMB_MASK1_ADDR |=> {2'b00, irq_mask} == ($past(sfr.wdata) & 8'h3f); endproperty
  a_wr: assert property (p_wr) else $error("mask write");
  property p_hold; !(sfr.wr && sfr.addr == `PIMB_MASK1_ADDR) |=> $stable(irq_mask); endproperty
  a_hold: assert property (p_hold) else $error("mask hold");
endmodule
bind pimb_mask_bank pimb_mask_bank_chk i_chk (.clk, .rst_n, .sfr, .sfr_rdata, .flags, .irq_req, .irq_mask);

// File: tb/pimb_mask_bank_tb.sv
`timescale 1ns/1ps
`include "pimb_map.svh"
module pimb_mask_bank_tb;
  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic [31:0]           s = 32'haf94;
  logic [6:0]            val = 7'h00;
  logic [5:0]            m = 6'h00;
  logic [5:0]            q[$];
  logic [13:0]           r[$];
  logic [13:0]           note;
  int                    failures = 0;
  int                    checks = 0;
  pimb_pkg::pimb_sfr_t   sfr = '0;
  pimb_pkg::pimb_flags_t flags;
  pimb_pkg::pimb_req_t   irq_req;
  logic [7:0]            sfr_rdata;
  logic [5:0]            irq_mask;
  always #5 clk = ~clk;
  pimb_flag_src i_pimb_flag_src (.clk, .val, .flags);
  pimb_mask_bank i_pimb_mask_bank (.clk, .rst_n, .sfr, .flags, .sfr_rdata, .irq_req, .irq_mask);
  function automatic logic [31:0] nx(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic cmp(input logic [7:0] a, input logic [7:0] b);
    checks++;
    if (a !== b) begin
      failures++;
      $display("wrong value %0t %h %h", $time, a, b);
    end
  endtask
  task close_out;
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    logic [13:0] got;
    #2;
    if (q.size() > 1) cmp(8'(irq_req), 8'(q.pop_front()));
    if (r.size() > 0) begin
      got = r.pop_front();
      cmp(sfr_rdata, got[13:6]);
      cmp(8'(irq_mask), 8'(got[5:0]));
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1;
    repeat (200) begin
      s = nx(s);
      // Hits the mask about half the time (s[2]), otherwise a random address
      sfr = {s[1:0], s[2] ? `PIMB_MASK1_ADDR : s[15:8], s[23:16]};
      val = s[30:24];
      // A read answers with the mask as it stood before this edge
      note[13:6] = (sfr.rd && sfr.addr == `PIMB_MASK1_ADDR) ? {2'b00, m} : 8'h00;
      if (sfr.wr && sfr.addr == `PIMB_MASK1_ADDR) m = s[21:16];
      note[5:0] = m;
      r.push_back(note);
      q.push_back({val[6] | val[5], val[4:0]} & m);
      @(negedge clk);
    end
    close_out;
  end
  initial begin
    #3000;
    failures++;
    close_out;
  end
endmodule
